/* File: shared/gptmr_defines.svh */
`ifndef GPTMR_DEFINES_SVH
`define GPTMR_DEFINES_SVH

// register byte offsets on the bus
`define GPTMR_OFF_COUNT     8'h00
`define GPTMR_OFF_PERIOD    8'h04
`define GPTMR_OFF_CONTROL   8'h08
`define GPTMR_OFF_STATUS    8'h0C

// control word fields
`define GPTMR_BIT_TIMER_ON  15
`define GPTMR_BIT_IDLE_STOP 13
`define GPTMR_BIT_GATE_EN   6
`define GPTMR_BIT_PS_HI     5
`define GPTMR_BIT_PS_LO     4
`define GPTMR_BIT_SYNC_SEL  2
`define GPTMR_BIT_CLK_SRC   1
`define GPTMR_CONTROL_MASK  16'hA076

// reset values
`define GPTMR_RST_COUNT     16'h0000
`define GPTMR_RST_PERIOD    16'hFFFF
`define GPTMR_RST_CONTROL   16'h0000

// prescale terminal counts (ratio minus one)
`define GPTMR_PS_DIV1       8'h00
`define GPTMR_PS_DIV8       8'h07
`define GPTMR_PS_DIV64      8'h3F
`define GPTMR_PS_DIV256     8'hFF

`endif

/* File: shared/gptmr_pkg.sv */
package gptmr_pkg;

    typedef enum logic [1:0] {
        GPTMR_PS_1,
        GPTMR_PS_8,
        GPTMR_PS_64,
        GPTMR_PS_256
    } gptmr_prescale_t;

    typedef enum logic [1:0] {
        GPTMR_MODE_TIMER,
        GPTMR_MODE_GATED,
        GPTMR_MODE_SYNC_CNT,
        GPTMR_MODE_ASYNC_CNT
    } gptmr_mode_t;

endpackage

/* File: shared/gptmr_tick_if.sv */
`timescale 1ns/1ps
interface gptmr_tick_if;
    logic                        tick;
    logic                        clear;
    gptmr_pkg::gptmr_prescale_t  ratio;
    logic                        out_tick;

    modport master (output tick, output clear, output ratio, input out_tick);
    modport slave  (input tick, input clear, input ratio, output out_tick);
endinterface

/* File: rtl/gptmr_sync3.sv */
`timescale 1ns/1ps
module gptmr_sync3 (
    input  wire logic aclk,     // system clock
    input  wire logic aresetn,  // synchronous reset, active low
    input  wire logic ce,       // clock enable
    input  wire logic pin,      // asynchronous pin
    output logic      level,    // filtered level
    output logic      rise,     // one-cycle rising edge
    output logic      fall      // one-cycle falling edge
);
    logic [2:0] sh_q;
    logic [2:0] sh_d;
    logic       level_q;
    logic       level_d;

    always_comb begin
        sh_d    = {sh_q[1:0], pin};
        level_d = level_q;
        // a change counts once stages two and three agree
        if (sh_q[1] == sh_q[2]) begin
            level_d = sh_q[2];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sh_q    <= 3'h0;
            level_q <= 1'b0;
        end else if (ce) begin
            sh_q    <= sh_d;
            level_q <= level_d;
        end
    end

    assign level = level_q;
    assign rise  = level_d & ~level_q & ce;
    assign fall  = ~level_d & level_q & ce;
endmodule // gptmr_sync3

/* File: rtl/gptmr_prescaler.sv */
`timescale 1ns/1ps
`include "gptmr_defines.svh"
module gptmr_prescaler (
    input  wire logic   aclk,     // system clock
    input  wire logic   aresetn,  // synchronous reset, active low
    input  wire logic   ce,       // clock enable
    gptmr_tick_if.slave ps        // tick in, divided tick out
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] term;
    logic       out_d;
    logic       out_q;

    function automatic logic [7:0] term_of(input gptmr_pkg::gptmr_prescale_t r);
        case (r)
            gptmr_pkg::GPTMR_PS_1:   term_of = `GPTMR_PS_DIV1;
            gptmr_pkg::GPTMR_PS_8:   term_of = `GPTMR_PS_DIV8;
            gptmr_pkg::GPTMR_PS_64:  term_of = `GPTMR_PS_DIV64;
            default:                 term_of = `GPTMR_PS_DIV256;
        endcase
    endfunction

    always_comb begin
        term  = term_of(ps.ratio);
        cnt_d = cnt_q;
        out_d = 1'b0;
        if (ps.clear) begin
            cnt_d = 8'h00;
        end else if (ps.tick) begin
            if (cnt_q >= term) begin
                cnt_d = 8'h00;
                out_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 8'h00;
            out_q <= 1'b0;
        end else if (ce) begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign ps.out_tick = out_q & ce;
endmodule // gptmr_prescaler

/* File: rtl/gptmr_timer.sv */
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "gptmr_defines.svh"
module gptmr_timer (
    input  wire logic        aclk,           // 25 MHz system clock
    input  wire logic        aresetn,        // synchronous reset, active low
    input  wire logic        ce,             // clock enable
    input  wire logic        instr_cycle,    // instruction cycle strobe
    input  wire logic        cpu_idle,       // cpu in idle
    input  wire logic        cpu_sleep,      // cpu in sleep
    input  wire logic        timer_clock_gate_pin, // external clock or gate
    output logic             match_event,    // one-cycle timer event
    output logic             period_match_flag, // sticky event flag
    input  wire logic [7:0]  s_axi_awaddr,   // write address
    input  wire logic        s_axi_awvalid,  // write address valid
    output logic             s_axi_awready,  // write address ready
    input  wire logic [31:0] s_axi_wdata,    // write data
    input  wire logic [3:0]  s_axi_wstrb,    // write strobes
    input  wire logic        s_axi_wvalid,   // write data valid
    output logic             s_axi_wready,   // write data ready
    output logic [1:0]       s_axi_bresp,    // write response
    output logic             s_axi_bvalid,   // write response valid
    input  wire logic        s_axi_bready,   // write response ready
    input  wire logic [7:0]  s_axi_araddr,   // read address
    input  wire logic        s_axi_arvalid,  // read address valid
    output logic             s_axi_arready,  // read address ready
    output logic [31:0]      s_axi_rdata,    // read data
    output logic [1:0]       s_axi_rresp,    // read response
    output logic             s_axi_rvalid,   // read data valid
    input  wire logic        s_axi_rready    // read data ready
);
    // bus state
    logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, ar_q, ar_d, rv_q, rv_d;
    logic [7:0]  awa_q, awa_d, ara_q, ara_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0]  ws_q, ws_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;
    logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;
    // timer state
    logic [15:0] count_value_q, count_value_d;
    logic [15:0] period_value_q, period_value_d;
    logic [15:0] control_q, control_d;
    logic        flag_q, flag_d, ev_q, ev_d;
    // derived
    logic        wr_fire, timer_on, idle_stop, gate_en, clk_src, sync_sel;
    logic        pin_level, pin_rise, pin_fall;
    logic        src_tick, inc, halted, gated_mode, cnt_wr, match_now;
    logic        ton_fall;
    logic [15:0] wr16;
    gptmr_pkg::gptmr_mode_t mode;
    gptmr_tick_if ps_if ();

    gptmr_sync3 u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .pin     (timer_clock_gate_pin),
        .level   (pin_level),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    gptmr_prescaler u_ps (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .ps      (ps_if.slave)
    );

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction

    // unaligned or unmapped addresses get an error response
    function automatic logic reg_hit(input logic [7:0] addr);
        reg_hit = (addr == `GPTMR_OFF_COUNT) || (addr == `GPTMR_OFF_PERIOD) ||
                  (addr == `GPTMR_OFF_CONTROL) || (addr == `GPTMR_OFF_STATUS);
    endfunction

    assign timer_on  = control_q[`GPTMR_BIT_TIMER_ON];
    assign idle_stop = control_q[`GPTMR_BIT_IDLE_STOP];
    assign gate_en   = control_q[`GPTMR_BIT_GATE_EN];
    assign clk_src   = control_q[`GPTMR_BIT_CLK_SRC];
    assign sync_sel  = control_q[`GPTMR_BIT_SYNC_SEL];

    // mode decode
    always_comb begin
        if (clk_src) begin
            mode = sync_sel ? gptmr_pkg::GPTMR_MODE_SYNC_CNT
                            : gptmr_pkg::GPTMR_MODE_ASYNC_CNT;
        end else if (gate_en) begin
            mode = gptmr_pkg::GPTMR_MODE_GATED;
        end else begin
            mode = gptmr_pkg::GPTMR_MODE_TIMER;
        end
    end

    assign gated_mode = timer_on & (mode == gptmr_pkg::GPTMR_MODE_GATED);

    // tick source and idle/sleep halting
    always_comb begin
        case (mode)
            gptmr_pkg::GPTMR_MODE_TIMER: begin
                src_tick = instr_cycle;
                halted   = (cpu_idle & idle_stop) | cpu_sleep;
            end
            gptmr_pkg::GPTMR_MODE_GATED: begin
                src_tick = instr_cycle & pin_level;
                halted   = (cpu_idle & idle_stop) | cpu_sleep;
            end
            gptmr_pkg::GPTMR_MODE_SYNC_CNT: begin
                src_tick = pin_rise;
                halted   = (cpu_idle & idle_stop) | cpu_sleep;
            end
            gptmr_pkg::GPTMR_MODE_ASYNC_CNT: begin
                // edges taken straight from the pin filter; runs in sleep
                src_tick = pin_rise;
                halted   = cpu_idle & idle_stop;
            end
            default: begin
                src_tick = 1'b0;
                halted   = 1'b1;
            end
        endcase
    end

    assign ton_fall = timer_on & ~control_d[`GPTMR_BIT_TIMER_ON];
    assign wr_fire  = aw_q & w_q & ~bv_q;
    assign wr16     = merge16(count_value_q, wd_q, ws_q);
    assign cnt_wr   = wr_fire & (awa_q == `GPTMR_OFF_COUNT);

    assign ps_if.tick  = timer_on & ~halted & src_tick;
    // clear only reaches the prescaler while its clock runs
    assign ps_if.clear = (timer_on & cnt_wr) | ton_fall;
    assign ps_if.ratio = gptmr_pkg::gptmr_prescale_t'(
                         control_q[`GPTMR_BIT_PS_HI:`GPTMR_BIT_PS_LO]);
    assign inc         = ps_if.out_tick & timer_on & ~halted;
    assign match_now   = inc & (count_value_q == period_value_q);

    // timer next state
    always_comb begin
        count_value_d  = count_value_q;
        period_value_d = period_value_q;
        control_d      = control_q;
        flag_d         = flag_q;
        ev_d           = 1'b0;
        if (inc) begin
            if (match_now) begin
                count_value_d = 16'h0000;
                ev_d          = 1'b1;
            end else begin
                count_value_d = count_value_q + 16'h0001;
            end
        end
        if (gated_mode & pin_fall) begin
            ev_d = 1'b1;
        end
        if (wr_fire) begin
            case (awa_q)
                `GPTMR_OFF_COUNT:   count_value_d  = wr16;
                `GPTMR_OFF_PERIOD:  period_value_d = merge16(period_value_q, wd_q, ws_q);
                `GPTMR_OFF_CONTROL: control_d = merge16(control_q, wd_q, ws_q)
                                                & `GPTMR_CONTROL_MASK;
                `GPTMR_OFF_STATUS:  if (ws_q[0] & wd_q[0]) flag_d = 1'b0;
                default:            ;
            endcase
        end
        if (ev_d) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_value_q  <= `GPTMR_RST_COUNT;
            period_value_q <= `GPTMR_RST_PERIOD;
            control_q      <= `GPTMR_RST_CONTROL;
            flag_q         <= 1'b0;
            ev_q           <= 1'b0;
        end else if (ce) begin
            count_value_q  <= count_value_d;
            period_value_q <= period_value_d;
            control_q      <= control_d;
            flag_q         <= flag_d;
            ev_q           <= ev_d;
        end
    end

    // bus next state
    always_comb begin
        aw_d  = aw_q;
        awa_d = awa_q;
        w_d   = w_q;
        wd_d  = wd_q;
        ws_d  = ws_q;
        bv_d  = bv_q;
        br_d  = br_q;
        ar_d  = ar_q;
        ara_d = ara_q;
        rv_d  = rv_q;
        rd_d  = rd_q;
        rr_d  = rr_q;
        if (s_axi_awvalid & ~aw_q) begin
            aw_d  = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid & ~w_q) begin
            w_d  = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (wr_fire) begin
            bv_d = 1'b1;
            br_d = reg_hit(awa_q) ? 2'h0 : 2'h2;
        end
        if (bv_q & s_axi_bready) begin
            bv_d = 1'b0;
            aw_d = 1'b0;
            w_d  = 1'b0;
        end
        if (s_axi_arvalid & ~ar_q & ~rv_q) begin
            ar_d  = 1'b1;
            ara_d = s_axi_araddr;
        end
        if (ar_q & ~rv_q) begin
            rv_d = 1'b1;
            rr_d = reg_hit(ara_q) ? 2'h0 : 2'h2;
            case (ara_q)
                `GPTMR_OFF_COUNT:   rd_d = {16'h0000, count_value_q};
                `GPTMR_OFF_PERIOD:  rd_d = {16'h0000, period_value_q};
                `GPTMR_OFF_CONTROL: rd_d = {16'h0000, control_q};
                `GPTMR_OFF_STATUS:  rd_d = {31'h00000000, flag_q};
                default: begin
                    rd_d = 32'h00000000;
                    rr_d = 2'h2;
                end
            endcase
        end
        if (rv_q & s_axi_rready) begin
            rv_d = 1'b0;
            ar_d = 1'b0;
        end
        // ready flags registered so every bus output leaves a flop
        awrdy_d = ~aw_d;
        wrdy_d  = ~w_d;
        arrdy_d = ~ar_d & ~rv_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q    <= 1'b0;
            awa_q   <= 8'h00;
            w_q     <= 1'b0;
            wd_q    <= 32'h00000000;
            ws_q    <= 4'h0;
            bv_q    <= 1'b0;
            br_q    <= 2'h0;
            ar_q    <= 1'b0;
            ara_q   <= 8'h00;
            rv_q    <= 1'b0;
            rd_q    <= 32'h00000000;
            rr_q    <= 2'h0;
            awrdy_q <= 1'b1;
            wrdy_q  <= 1'b1;
            arrdy_q <= 1'b1;
        end else if (ce) begin
            aw_q    <= aw_d;
            awa_q   <= awa_d;
            w_q     <= w_d;
            wd_q    <= wd_d;
            ws_q    <= ws_d;
            bv_q    <= bv_d;
            br_q    <= br_d;
            ar_q    <= ar_d;
            ara_q   <= ara_d;
            rv_q    <= rv_d;
            rd_q    <= rd_d;
            rr_q    <= rr_d;
            awrdy_q <= awrdy_d;
            wrdy_q  <= wrdy_d;
            arrdy_q <= arrdy_d;
        end
    end

    assign s_axi_awready     = awrdy_q;
    assign s_axi_wready      = wrdy_q;
    assign s_axi_bvalid      = bv_q;
    assign s_axi_bresp       = br_q;
    assign s_axi_arready     = arrdy_q;
    assign s_axi_rvalid      = rv_q;
    assign s_axi_rdata       = rd_q;
    assign s_axi_rresp       = rr_q;
    assign match_event       = ev_q;
    assign period_match_flag = flag_q;
endmodule // gptmr_timer

/* File: sim/gptmr_timer_chk.sv */
`timescale 1ns/1ps
module gptmr_timer_chk (
    input wire logic        aclk,              // clock
    input wire logic        aresetn,           // reset, active low
    input wire logic        ce,                // clock enable
    input wire logic        match_event,       // event pulse
    input wire logic        period_match_flag, // sticky flag
    input wire logic        s_axi_awvalid,     // aw valid
    input wire logic        s_axi_awready,     // aw ready
    input wire logic        s_axi_wvalid,      // w valid
    input wire logic        s_axi_wready,      // w ready
    input wire logic [1:0]  s_axi_bresp,       // b resp
    input wire logic        s_axi_bvalid,      // b valid
    input wire logic        s_axi_bready,      // b ready
    input wire logic        s_axi_arvalid,     // ar valid
    input wire logic        s_axi_arready,     // ar ready
    input wire logic [31:0] s_axi_rdata,       // r data
    input wire logic        s_axi_rvalid,      // r valid
    input wire logic        s_axi_rready       // r ready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_take;
        ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        ce && s_axi_arvalid && s_axi_arready;
    endsequence

    chk_aw_refuse: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready)
        else $error("write channels ready again before response");
    chk_b_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_b_release: assert property (ce && s_axi_bvalid && s_axi_bready |=> s_axi_awready)
        else $error("write address not ready after response");
    chk_ar_refuse: assert property (s_rd_take |=> !s_axi_arready)
        else $error("read address ready again before data");
    chk_r_answer: assert property (s_rd_take |-> ##[1:3] s_axi_rvalid)
        else $error("read data late");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_flag_set: assert property (match_event |-> ##[0:1] period_match_flag)
        else $error("flag not set by event");
    chk_flag_clear: assert property ($fell(period_match_flag) |-> !s_axi_awready)
        else $error("flag cleared without a write");
endmodule // gptmr_timer_chk

bind gptmr_timer gptmr_timer_chk chk_i (.aclk, .aresetn, .ce, .match_event, .period_match_flag,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

/* File: sim/gptmr_pin_model.sv */
`timescale 1ns/1ps
module gptmr_pin_model (
    input wire logic       aclk,       // clock
    input wire logic       gate_mode,  // pin carries gate level
    input wire logic       gate_level, // gate level wanted
    input wire logic       start,      // begin a clock burst
    input wire logic [7:0] n_edges,    // rising edges in burst
    input wire logic [3:0] half,       // half period in cycles
    output logic           pin,        // timer pin
    output logic           busy        // burst running
);
    logic [7:0] left_q = 8'h00;
    logic [3:0] cnt_q  = 4'h0;
    logic       clk_q  = 1'b0;
    // external clock stands low between bursts
    always @(posedge aclk) begin
        if (start) begin
            left_q <= n_edges;
            cnt_q  <= 4'h0;
            clk_q  <= 1'b0;
        end else if (left_q != 8'h00) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == half - 4'h1) begin
                cnt_q <= 4'h0;
                clk_q <= ~clk_q;
                if (clk_q) left_q <= left_q - 8'h01;
            end
        end
    end
    assign pin  = gate_mode ? gate_level : clk_q;
    assign busy = (left_q != 8'h00);
endmodule // gptmr_pin_model

/* File: sim/gp_timer_16bit_gated_test.sv */
`timescale 1ns/1ps
`include "gptmr_defines.svh"
module gp_timer_16bit_gated_test;
    logic        aclk = 0, aresetn = 0, ce = 1, instr_cycle = 1, cpu_idle = 0, cpu_sleep = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, n_edges = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h0000AD7C;
    logic [3:0]  s_axi_wstrb = 4'hF, half = 4'h4;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, gate_mode = 0, gate_level = 0, start = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        match_event, period_match_flag, timer_clock_gate_pin, busy;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] v;
    int          fail_count = 0, num_checks = 0, cyc = 0, p, n, g, ne, k, ps, i;
    logic [15:0] ctl[4] = '{16'h8006, 16'h8002, 16'h8006, 16'hA002};
    logic [3:0]  slp = 4'h6, idl = 4'h8, full = 4'h3;

    gptmr_timer uut (.aclk, .aresetn, .ce, .instr_cycle, .cpu_idle, .cpu_sleep,
        .timer_clock_gate_pin, .match_event, .period_match_flag, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    gptmr_pin_model pm (.aclk, .gate_mode, .gate_level, .start, .n_edges, .half,
        .pin(timer_clock_gate_pin), .busy);

    always #20 aclk = ~aclk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int ratio(input int code);
        return code == 0 ? 1 : code == 1 ? 8 : code == 2 ? 64 : 256;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk(s_axi_rresp, er);
    endtask
    // cycles from one event to the next
    task automatic gap(output int m);
        m = 0;
        while (!match_event && m < 3000) begin
            @(posedge aclk);
            m++;
        end
        m = 0;
        do begin
            @(posedge aclk);
            m++;
        end while (!match_event && m < 3000);
    endtask
    task final_report();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`GPTMR_OFF_COUNT, 0, 0);
        rd(`GPTMR_OFF_PERIOD, 32'h0000FFFF, 0);
        rd(`GPTMR_OFF_CONTROL, 0, 0);
        rd(`GPTMR_OFF_STATUS, 0, 0);
        rd(8'h10, 0, 2);
        wr(8'h10, 32'h0000FFFF, 2);
        v = rnd();
        wr(`GPTMR_OFF_COUNT, v, 0);
        wr(`GPTMR_OFF_CONTROL, 32'h00007FFF, 0);
        rd(`GPTMR_OFF_CONTROL, 32'h00002076, 0);
        rd(`GPTMR_OFF_COUNT, v, 0);
        $display("test registers done");
        for (ps = 0; ps < 4; ps++) begin
            p = int'(rnd() % 8) + 2;
            wr(`GPTMR_OFF_PERIOD, p, 0);
            wr(`GPTMR_OFF_COUNT, 0, 0);
            cpu_idle <= ps[0];
            wr(`GPTMR_OFF_CONTROL, 32'h8000 | (ps << 4), 0);
            gap(n);
            gap(n);
            chk(n, (p + 1) * ratio(ps));
        end
        wr(`GPTMR_OFF_CONTROL, 32'h0000A000, 0);
        cpu_idle <= 1'b1;
        repeat (4) @(posedge aclk);
        repeat (40) begin
            @(posedge aclk);
            chk(match_event, 0);
        end
        cpu_idle <= 1'b0;
        gap(n);
        gap(n);
        chk(n, p + 1);
        // clock enable low: no event and no progress, then the same period again
        ce <= 1'b0;
        repeat (40) begin
            @(posedge aclk);
            chk(match_event, 0);
        end
        ce <= 1'b1;
        gap(n);
        chk(n, p + 1);
        $display("test timer done");
        wr(`GPTMR_OFF_CONTROL, 0, 0);
        wr(`GPTMR_OFF_PERIOD, 32'h0000FFFF, 0);
        wr(`GPTMR_OFF_COUNT, 0, 0);
        wr(`GPTMR_OFF_STATUS, 1, 0);
        rd(`GPTMR_OFF_STATUS, 0, 0);
        gate_mode <= 1'b1;
        wr(`GPTMR_OFF_CONTROL, 32'h00008040, 0);
        g = int'(rnd() % 30) + 20;
        gate_level <= 1'b1;
        repeat (g) @(posedge aclk);
        gate_level <= 1'b0;
        k = 0;
        while (!match_event && k < 12) begin
            @(posedge aclk);
            k++;
        end
        chk(match_event, 1);
        rd(`GPTMR_OFF_COUNT, g, 0);
        rd(`GPTMR_OFF_STATUS, 1, 0);
        wr(`GPTMR_OFF_STATUS, 1, 0);
        rd(`GPTMR_OFF_STATUS, 0, 0);
        gate_mode <= 1'b0;
        $display("test gated done");
        for (i = 0; i < 4; i++) begin
            wr(`GPTMR_OFF_CONTROL, 0, 0);
            wr(`GPTMR_OFF_COUNT, 0, 0);
            cpu_sleep <= slp[i];
            cpu_idle <= idl[i];
            wr(`GPTMR_OFF_CONTROL, ctl[i], 0);
            ne = int'(rnd() % 20) + 5;
            n_edges <= ne[7:0];
            half <= 4'(rnd() % 6) + 4'h3;
            start <= 1'b1;
            @(posedge aclk);
            start <= 1'b0;
            repeat (2) @(posedge aclk);
            while (busy) @(posedge aclk);
            repeat (10) @(posedge aclk);
            rd(`GPTMR_OFF_COUNT, full[i] ? ne : 0, 0);
            cpu_sleep <= 1'b0;
            cpu_idle <= 1'b0;
        end
        $display("test external done");
        final_report();
    end
endmodule // gp_timer_16bit_gated_test
